// File: rtl/direct_mapped_external_cache.sv
// Direct-mapped external cache: control register, tag/data arrays, fill sequencer
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module direct_mapped_external_cache #(
	parameter int ENTRIES = cache_pkg::ENTRIES
) (
	// Clock and power-on reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Register and array port
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Processor fetch side
	input  wire logic        fetch_req,
	input  wire logic [31:0] fetch_addr,
	input  wire logic        fetch_cacheable_kind,
	output logic             fetch_done,
	output logic      [31:0] fetch_data,
	// External bus controller side
	output logic             ext_req,
	output logic      [31:0] ext_addr,
	output logic             ext_fill,
	output logic             ext_cs_stretch,
	output logic             ext_ras_stretch,
	output logic             ext_hold_next,
	input  wire logic        ext_done,
	input  wire logic        ext_last,
	input  wire logic [31:0] ext_rdata,
	input  wire logic        ras_down_mode
);
	initial begin
		if (ENTRIES != cache_pkg::ENTRIES)
			$error("ENTRIES must match the index width");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_BUS  = 2'b11,
		ST_HOLD = 2'b10
	} fill_state_e;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [cache_pkg::INDEX_W-1:0] index_of(input logic [31:0] a);
		index_of = a[cache_pkg::INDEX_LSB +: cache_pkg::INDEX_W];
	endfunction

	logic [15:0]                   cache_control_reg;
	logic [cache_pkg::TAG_W-1:0]   tag_mem [ENTRIES];
	logic [ENTRIES-1:0]            valid_mem;
	logic [31:0]                   data_mem [ENTRIES];
	fill_state_e                   state;
	logic                          last_was_miss;
	logic [31:0]                   miss_addr;
	logic                          miss_dram;

	logic                          any_enabled;
	logic                          hit_tag;
	logic                          wr_tag;
	logic                          wr_data;
	logic                          space_ok;
	logic                          fetch_dram;
	logic [1:0]                    fetch_space;
	logic [cache_pkg::INDEX_W-1:0] fidx;
	logic [cache_pkg::INDEX_W-1:0] ridx;
	logic [cache_pkg::INDEX_W-1:0] midx;
	logic                          fill_wr;

	assign any_enabled = |cache_control_reg[4:0];
	assign ridx        = index_of(reg_addr);
	assign fidx        = index_of(fetch_addr);
	assign midx        = index_of(miss_addr);
	// Forced access only takes effect while every space is uncached
	assign wr_tag  = reg_wr && !any_enabled &&
		in_range(reg_addr, cache_pkg::TAG_ARRAY_BASE, cache_pkg::TAG_ARRAY_LAST);
	assign wr_data = reg_wr && !any_enabled &&
		in_range(reg_addr, cache_pkg::DATA_ARRAY_BASE, cache_pkg::DATA_ARRAY_LAST);
	assign fetch_dram  = fetch_addr[31:24] == cache_pkg::DRAM_SPACE_TOP;
	assign fetch_space = fetch_addr[23:22];
	assign space_ok = fetch_cacheable_kind && (fetch_dram ?
		cache_control_reg[cache_pkg::DRAM_EN_BIT] :
		(fetch_addr[31:24] == cache_pkg::EXT_SPACE_TOP) &&
		cache_control_reg[cache_pkg::SPACE_EN_LSB + fetch_space]);
	assign hit_tag = valid_mem[fidx] &&
		(tag_mem[fidx] == fetch_addr[cache_pkg::TAG_LSB +: cache_pkg::TAG_W]);
	assign fill_wr = (state == ST_BUS) && ext_done && ext_last;

	// ****************************************************************
	// Control register
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cache_control_reg <= cache_pkg::CACHE_CONTROL_RST;
		end else if (reg_wr && reg_addr == cache_pkg::CACHE_CONTROL_ADDR) begin
			cache_control_reg <= {11'h000, reg_wdata[4:0] & cache_pkg::CACHE_CONTROL_MASK};
		end
	end

	// ****************************************************************
	// Register and array read port
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_addr == cache_pkg::CACHE_CONTROL_ADDR) begin
			reg_rdata <= {16'h0000, cache_control_reg};
		end else if (any_enabled) begin
			// Contents are undefined while cached; zero avoids leaking line data
			reg_rdata <= 32'h0000_0000;
		end else if (in_range(reg_addr, cache_pkg::TAG_ARRAY_BASE,
			cache_pkg::TAG_ARRAY_LAST)) begin
			reg_rdata <= {valid_mem[ridx], 6'h00, tag_mem[ridx], 10'h000};
		end else if (in_range(reg_addr, cache_pkg::DATA_ARRAY_BASE,
			cache_pkg::DATA_ARRAY_LAST)) begin
			reg_rdata <= data_mem[ridx];
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ****************************************************************
	// Tag array: forced writes and fills
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			valid_mem <= '0;
		end else if (wr_tag) begin
			valid_mem[ridx] <= reg_wdata[cache_pkg::VALID_BIT];
		end else if (fill_wr) begin
			valid_mem[midx] <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (wr_tag) begin
			tag_mem[ridx] <= reg_wdata[cache_pkg::TAG_LSB +: cache_pkg::TAG_W];
		end else if (fill_wr) begin
			tag_mem[midx] <= miss_addr[cache_pkg::TAG_LSB +: cache_pkg::TAG_W];
		end
	end

	// ****************************************************************
	// Data array
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (wr_data) begin
			data_mem[ridx] <= reg_wdata;
		end else if (fill_wr) begin
			data_mem[midx] <= ext_rdata;
		end
	end

	// ****************************************************************
	// Fetch and fill sequencer
	// ****************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state           <= ST_IDLE;
			last_was_miss   <= 1'b0;
			miss_addr       <= 32'h0000_0000;
			miss_dram       <= 1'b0;
			fetch_done      <= 1'b0;
			fetch_data      <= 32'h0000_0000;
			ext_req         <= 1'b0;
			ext_addr        <= 32'h0000_0000;
			ext_fill        <= 1'b0;
			ext_cs_stretch  <= 1'b0;
			ext_ras_stretch <= 1'b0;
			ext_hold_next   <= 1'b0;
		end else begin
			fetch_done    <= 1'b0;
			ext_hold_next <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (fetch_req) begin
						miss_addr <= fetch_addr;
						miss_dram <= fetch_dram;
						if (space_ok && hit_tag && !last_was_miss) begin
							fetch_data    <= data_mem[fidx];
							fetch_done    <= 1'b1;
							last_was_miss <= 1'b0;
						end else if (space_ok && last_was_miss) begin
							// Follows a miss: fill at once, hit or not
							state           <= ST_BUS;
							ext_req         <= 1'b1;
							ext_addr        <= fetch_addr;
							ext_fill        <= 1'b1;
							ext_cs_stretch  <= !fetch_dram;
							ext_ras_stretch <= fetch_dram;
						end else if (space_ok) begin
							state <= ST_WAIT;
						end else begin
							// Uncached fetch goes straight out with ext_fill low, yet its answer is still written into the arrays
							state         <= ST_BUS;
							ext_req       <= 1'b1;
							ext_addr      <= fetch_addr;
							ext_fill      <= 1'b0;
							last_was_miss <= 1'b0;
						end
					end else if (!fetch_done) begin
						// The chain survives the cycle in which the answer stands, so a
						// requester that reacts to fetch_done still counts as consecutive
						last_was_miss <= 1'b0;
					end
				end
				ST_WAIT: begin
					state           <= ST_BUS;
					ext_req         <= 1'b1;
					ext_addr        <= miss_addr;
					ext_fill        <= 1'b1;
					ext_cs_stretch  <= !miss_dram;
					ext_ras_stretch <= miss_dram;
				end
				ST_BUS: begin
					if (ext_done && ext_last) begin
						ext_req         <= 1'b0;
						ext_fill        <= 1'b0;
						ext_cs_stretch  <= 1'b0;
						ext_ras_stretch <= 1'b0;
						fetch_data      <= ext_rdata;
						fetch_done      <= 1'b1;
						last_was_miss   <= ext_fill;
						if (ext_fill && miss_dram && ras_down_mode) begin
							state         <= ST_HOLD;
							ext_hold_next <= 1'b1;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_HOLD: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: rtl/cache_pkg.sv
// Constants, register layout and fill timing for the direct-mapped external cache
//
// How it works
// - Control register is 16 bits, cleared only by power-on reset.
// - Bits 15..5 are reserved, read back zero; software writes zero.
// - Bit 4 makes DRAM space cacheable when set.
// - Bits 3..0 make chip-select spaces 3..0 cacheable when set.
// - Tag array mapped as 1 kbyte 32-bit region for forced access.
// - Data array mapped as 1 kbyte region directly above tag array.
// - With caching off both arrays act as ordinary on-chip RAM; each fetch still writes its answer into them.
// - Tag region read returns addressed entry's tag and valid bit.
// - Tag region write stores tag and valid bit at addressed entry.
// - Data region access reads or writes addressed line's word.
// - While any caching is on, array writes are dropped, reads undefined.
// - An isolated miss gets one idle cycle before the fill.
// - Back-to-back misses: only the first one gets the idle cycle.
// - Chip-select fill stretches the final chip-select assertion one cycle.
// - DRAM fill stretches the row strobe one cycle before cycle end.
// - With row strobe held low, a DRAM fill delays the next bus cycle.
// - First hit after a miss is filled like a miss, without idle cycle.
// - 256 entries, each a 15-bit tag plus a valid bit.
// - Direct mapped; a miss replaces the single indexed entry.
// - Only instruction and PC-relative reads to external spaces are cached; uncached fetches still write their answers into the arrays.
package cache_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [31:0] CACHE_CONTROL_ADDR = 32'hffff_8740;
	localparam logic [31:0] TAG_ARRAY_BASE     = 32'hffff_f000;
	localparam logic [31:0] TAG_ARRAY_LAST     = 32'hffff_f3ff;
	localparam logic [31:0] DATA_ARRAY_BASE    = 32'hffff_f400;
	localparam logic [31:0] DATA_ARRAY_LAST    = 32'hffff_f7ff;
	localparam logic [15:0] CACHE_CONTROL_RST  = 16'h0000;
	localparam logic [4:0]  CACHE_CONTROL_MASK = 5'h1f;
	localparam int          DRAM_EN_BIT        = 4;
	localparam int          SPACE_EN_LSB       = 0;
	localparam int          NUM_SPACES         = 4;
	// ****************************************************************
	// Array geometry and address split
	// ****************************************************************
	localparam int          ENTRIES            = 256;
	localparam int          INDEX_W            = 8;
	localparam int          TAG_W              = 15;
	localparam int          INDEX_LSB          = 2;
	localparam int          TAG_LSB            = 10;
	localparam int          VALID_BIT          = 31;
	// Space decode: high byte zero, A23..A22 pick chip-select space
	localparam logic [7:0]  EXT_SPACE_TOP      = 8'h00;
	localparam logic [7:0]  DRAM_SPACE_TOP     = 8'h01;
	localparam logic [15:0] ARRAY_TOP          = 16'hffff;
endpackage

// File: testbench/ext_bus_model.sv
// Bus controller model that answers the cache's external reads
`timescale 1ns/100ps
`default_nettype none
module ext_bus_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Request from the cache
	input  wire logic        ext_req,
	input  wire logic [31:0] ext_addr,
	input  wire logic        slow,
	// Answer
	output logic             ext_done,
	output logic             ext_last,
	output logic      [31:0] ext_rdata
);
	logic [1:0] wait_cnt;
	// One line per fill, so every done is also the final beat
	assign ext_last = ext_done;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wait_cnt  <= 2'h0;
			ext_done  <= 1'b0;
			ext_rdata <= 32'h0000_0000;
		end else begin
			ext_done  <= ext_req && !ext_done && (wait_cnt == {slow, 1'b0});
			wait_cnt  <= (ext_req && !ext_done) ? wait_cnt + 2'h1 : 2'h0;
			// Outside an answer the data flips, so a stale sample never matches
			ext_rdata <= (ext_req && !ext_done) ? (ext_addr ^ 32'h5a5a_c3c3) : ~ext_rdata;
		end
	end
endmodule
`default_nettype wire

// File: testbench/direct_mapped_external_cache_properties.sv
// Concurrent checks on the cache's register port and fill timing
`timescale 1ns/100ps
`default_nettype none
module cache_checker #(
	parameter int ENTRIES = 256
) (
	// Clock, reset and register port
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_rdata,
	// Fetch side and external bus
	input  wire logic        fetch_req,
	input  wire logic [31:0] fetch_addr,
	input  wire logic        fetch_cacheable_kind,
	input  wire logic        fetch_done,
	input  wire logic [31:0] fetch_data,
	input  wire logic        ext_req,
	input  wire logic [31:0] ext_addr,
	input  wire logic        ext_fill,
	input  wire logic        ext_cs_stretch,
	input  wire logic        ext_ras_stretch,
	input  wire logic        ext_hold_next,
	input  wire logic        ext_done,
	input  wire logic        ext_last,
	input  wire logic [31:0] ext_rdata,
	input  wire logic        ras_down_mode
);
	// ****************************************************************
	// Shadow state
	// ****************************************************************
	logic [4:0] ctrl;
	logic       fill_seen;
	logic       fill_seen2;
	wire        chain_win = fill_seen || fill_seen2;
	wire        ctl_hit = reg_addr == cache_pkg::CACHE_CONTROL_ADDR;
	wire        arr_hit = reg_addr[31:11] == cache_pkg::TAG_ARRAY_BASE[31:11];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			ctrl <= 5'h00;
		else if (reg_wr && ctl_hit)
			ctrl <= reg_wdata[4:0];
	end
	// A fetch in either of the two cycles after the fill's answer counts as a chained miss
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fill_seen  <= 1'b0;
			fill_seen2 <= 1'b0;
		end else begin
			fill_seen  <= ext_req && ext_fill && ext_done && ext_last;
			fill_seen2 <= fill_seen;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence fill_end_s;
		ext_req && ext_done && ext_last;
	endsequence
	sequence chained_req_s;
		fetch_req && fetch_cacheable_kind && chain_win && fetch_addr[31:24] == 8'h00
			&& ctrl[fetch_addr[23:22]];
	endsequence
	ctrl_readback_a: assert property (reg_rd && ctl_hit |=> reg_rdata == {27'h0, $past(ctrl)})
		else $error("control read mismatch");
	array_lockout_a: assert property (reg_rd && arr_hit && ctrl != 5'h00 |=> reg_rdata == 32'h0)
		else $error("array read while enabled");
	miss_idle_a: assert property (fetch_req && !chain_win |=> !(ext_req && ext_fill))
		else $error("fill without idle cycle");
	chained_fill_a: assert property (chained_req_s |=> ext_req && ext_fill && ext_addr[31:2] == $past(fetch_addr[31:2]))
		else $error("chained fill late");
	cs_stretch_a: assert property (ext_req && ext_fill && ext_addr[31:24] == 8'h00 |-> ext_cs_stretch && !ext_ras_stretch)
		else $error("select stretch missing");
	ras_stretch_a: assert property (ext_req && ext_fill && ext_addr[31:24] == 8'h01 |-> ext_ras_stretch && !ext_cs_stretch)
		else $error("row stretch missing");
	ras_hold_a: assert property (fill_end_s ##0 (ext_ras_stretch && ras_down_mode) |=> ext_hold_next)
		else $error("next cycle not delayed");
	fill_return_a: assert property (fill_end_s |=> fetch_done && !ext_req && fetch_data == $past(ext_rdata))
		else $error("fill data not returned");
	bus_hold_a: assert property (ext_req && !ext_done |=> ext_req && $stable(ext_addr) && $stable(ext_fill))
		else $error("external request dropped");
endmodule
bind direct_mapped_external_cache cache_checker #(.ENTRIES(ENTRIES)) chk (.*);
`default_nettype wire

// File: testbench/direct_mapped_external_cache_tb.sv
// Self-checking bench for the direct-mapped external cache
`timescale 1ns/100ps
`default_nettype none
module direct_mapped_external_cache_tb;
	localparam logic [31:0] CTRL = cache_pkg::CACHE_CONTROL_ADDR;
	localparam logic [31:0] TAG  = cache_pkg::TAG_ARRAY_BASE;
	localparam logic [31:0] DAT  = cache_pkg::DATA_ARRAY_BASE;
	logic        clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, fetch_req = 0, slow = 0, rd_q = 0;
	logic        fetch_cacheable_kind = 0, ras_down_mode = 0, fetch_done, ext_req, ext_fill;
	logic        ext_cs_stretch, ext_ras_stretch, ext_hold_next, ext_done, ext_last;
	logic [31:0] reg_addr = 0, reg_wdata = 0, fetch_addr = 0, reg_rdata, fetch_data, ext_addr;
	logic [31:0] ext_rdata, w, reg_q[$], fet_q[$], mem[256];
	int          err_total = 0, comparisons = 0, n;
	direct_mapped_external_cache #(.ENTRIES(256)) uut (.*);
	ext_bus_model bus (.*);
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic end_sim;
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Called at an edge; leaves the strobe up so accesses run back to back
	task automatic acc(input logic wr, input logic [31:0] a, d, e);
		reg_wr    <= wr;
		reg_rd    <= !wr;
		reg_addr  <= a;
		reg_wdata <= d;
		if (!wr)
			reg_q.push_back(e);
		@(posedge clk);
	endtask
	// Hit: 1 = must hit, 0 = must go external, 2 = either
	task automatic fetch(input logic [31:0] a, input logic k, input int hit);
		int c;
		reg_wr               <= 0;
		reg_rd               <= 0;
		slow                 <= 1'($urandom);
		fetch_req            <= 1;
		fetch_addr           <= a;
		fetch_cacheable_kind <= k;
		fet_q.push_back(a ^ 32'h5a5a_c3c3);
		@(posedge clk);
		fetch_req <= 0;
		c = 1;
		while (!fetch_done && c < 200) begin
			@(posedge clk);
			c++;
		end
		if (c >= 200) begin
			err_total++;
			end_sim();
		end
		if (hit != 2)
			chk(32'(c == 2), 32'(hit));
	endtask
	always @(posedge clk) begin
		rd_q <= reg_rd;
		if (rd_q)
			chk(reg_rdata, reg_q.pop_front());
		if (fetch_done)
			chk(fetch_data, fet_q.pop_front());
	end
	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial begin
		n = $urandom(32'h5fba_8f08);
		repeat (16) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		acc(0, CTRL, 0, 0);
		for (int i = 0; i < 256; i++) begin
			mem[i] = $urandom;
			acc(1, TAG + 32'(4 * i), 0, 0);
			acc(1, DAT + 32'(4 * i), mem[i], 0);
		end
		for (int i = 0; i < 4; i++) begin
			n = $urandom_range(0, 255);
			w = {1'b1, 6'h00, 15'($urandom), 10'h000};
			acc(1, TAG + 32'(4 * n), w, 0);
			acc(0, TAG + 32'(4 * n), 0, w);
			acc(0, DAT + 32'(4 * n), 0, mem[n]);
			acc(1, TAG + 32'(4 * n), 0, 0);
		end
		acc(1, 32'hffff_f800, 32'h1234_5678, 0);
		acc(0, 32'hffff_f800, 0, 0);
		for (int i = 0; i < 5; i++) begin
			acc(1, CTRL, 32'h1 << i, 0);
			acc(0, CTRL, 0, 32'h1 << i);
			acc(1, DAT, ~mem[0], 0);
			acc(0, DAT, 0, 0);
		end
		acc(1, CTRL, 0, 0);
		acc(0, DAT, 0, mem[0]);
		acc(1, CTRL, 32'h11, 0);
		fetch(32'h0000_0100, 1, 0);
		@(posedge clk);
		fetch(32'h0000_0100, 1, 1);
		@(posedge clk);
		fetch(32'h0000_0500, 1, 0);
		fetch(32'h0000_0104, 1, 0);
		fetch(32'h0000_0100, 1, 0);
		fetch(32'h0000_0104, 1, 0);
		@(posedge clk);
		fetch(32'h0000_0104, 1, 1);
		@(posedge clk);
		fetch(32'h0000_0104, 0, 0);
		repeat (2) begin
			@(posedge clk);
			fetch(32'h0040_0010, 1, 0);
		end
		ras_down_mode <= 1;
		fetch(32'h0100_0040, 1, 0);
		repeat (3) @(posedge clk);
		fetch(32'h0100_0040, 1, 1);
		ras_down_mode <= 0;
		repeat (40) begin
			if (1'($urandom))
				@(posedge clk);
			fetch({24'h00_0000, 6'($urandom), 2'b00}, 1, 2);
		end
		repeat (3) @(posedge clk);
		end_sim();
	end
endmodule
`default_nettype wire
